// ===== core/sfir_map.vh
/*
 symmetric fir filter: named constants for widths, tap count, clear polarity
 and reset values. assumes nothing of its surroundings.
*/
`ifndef SFIR_MAP_VH
`define SFIR_MAP_VH

// widths and tap count as built
`define SFIR_D_WIDTH 8
`define SFIR_D_MIN 2
`define SFIR_D_MAX 16
`define SFIR_TAPS 12
`define SFIR_TAPS_MAX 64
`define SFIR_UNIQ ((`SFIR_TAPS / 2) + (`SFIR_TAPS % 2))
`define SFIR_TAPS_LOG2 4
`define SFIR_FULL_RES (2 * `SFIR_D_WIDTH + `SFIR_TAPS_LOG2)
// 0 selects full resolution
`define SFIR_O_WIDTH 0
`define SFIR_O_MIN 3
`define SFIR_O_MAX 64
`define SFIR_O_EFF ((`SFIR_O_WIDTH == 0) ? `SFIR_FULL_RES : `SFIR_O_WIDTH)

// clear polarity selections
`define SFIR_CLR_NONE 2
`define SFIR_CLR_HIGH 1
`define SFIR_CLR_LOW 0
`define SFIR_CLR_SEL `SFIR_CLR_HIGH

// io register option: 1 inserts input and output registers
`define SFIR_IOREG 1

// unique coefficients packed low index first, d_width bits each
`define SFIR_COEF_VEC {8'h03, 8'h00, 8'hf6, 8'h00, 8'h27, 8'h40}

`define SFIR_ZERO_D {`SFIR_D_WIDTH{1'b0}}

`endif

// ===== core/sfir_cmul.v
/*
 signed multiply-by-constant unit for one coefficient.
 assumes a signed sample on data_in; the product is purely combinational.
*/
`timescale 1ns/1ps
`default_nettype none
`include "sfir_map.vh"

module sfir_cmul #(
    parameter [`SFIR_D_WIDTH-1:0] coef = `SFIR_ZERO_D
) (
    input wire signed [`SFIR_D_WIDTH-1:0] data_in,
    output wire signed [2*`SFIR_D_WIDTH-1:0] prod
);

// =======================================================
// constant product
// a zero coefficient leaves no logic at all
generate
    if (coef == `SFIR_ZERO_D) begin : g_zero
        assign prod = {(2*`SFIR_D_WIDTH){1'b0}};
    end else begin : g_mul
        wire signed [`SFIR_D_WIDTH-1:0] k = coef;
        assign prod = data_in * k;
    end
endgenerate

endmodule
`default_nettype wire

// ===== core/sfir_top.v
/*
 symmetric transposed-form fir filter, fully parallel, with optional io
 registers and a configurable asynchronous clear.
 assumes upstream supplies one signed sample per clk edge and downstream
 takes one result per edge; rstn is a synchronous active-low reset.
 assumes aclr is released away from the active clk edge, and that the
 build is chosen by editing the macros of sfir_map.vh, which are checked
 below at elaboration.
*/
`timescale 1ns/1ps
`default_nettype none
`include "sfir_map.vh"

module sfir_top (
    input wire clk,
    input wire rstn,
    input wire aclr,
    input wire signed [`SFIR_D_WIDTH-1:0] sample_in,
    output wire signed [`SFIR_O_EFF-1:0] result_out
);

localparam integer DW = `SFIR_D_WIDTH;
localparam integer NT = `SFIR_TAPS;
localparam integer NU = `SFIR_UNIQ;
localparam integer FR = `SFIR_FULL_RES;
localparam integer OW = `SFIR_O_EFF;
localparam integer PW = 2 * DW;
localparam [NU*DW-1:0] COEFS = `SFIR_COEF_VEC;

// =======================================================
// build-time range checks: an illegal setting fails elaboration
// a negative replication count is refused by every elaborator, which
// stops a bad build without naming a module that does not exist
generate
    if (NT < 1 || NT > `SFIR_TAPS_MAX) begin : g_bad_taps
        localparam [0:0] TAP_COUNT_OUT_OF_RANGE = {(-1){1'b0}};
    end
    if (DW < `SFIR_D_MIN || DW > `SFIR_D_MAX) begin : g_bad_dw
        localparam [0:0] DATA_WIDTH_OUT_OF_RANGE = {(-1){1'b0}};
    end
    if (OW < `SFIR_O_MIN || OW > `SFIR_O_MAX) begin : g_bad_ow
        localparam [0:0] RESULT_WIDTH_OUT_OF_RANGE = {(-1){1'b0}};
    end
    if ((1 << `SFIR_TAPS_LOG2) < NT) begin : g_bad_log2
        // the growth allowance must cover the tap count or sums wrap
        localparam [0:0] GROWTH_TOO_SMALL = {(-1){1'b0}};
    end
    if (`SFIR_CLR_SEL > `SFIR_CLR_NONE) begin : g_bad_clr
        localparam [0:0] CLEAR_SELECT_UNKNOWN = {(-1){1'b0}};
    end
endgenerate

// =======================================================
// clear decode
// clear is asynchronous by intent; synchronous rstn clears the same state
wire clr_act;
generate
    if (`SFIR_CLR_SEL == `SFIR_CLR_HIGH) begin : g_clr_hi
        assign clr_act = aclr;
    end else if (`SFIR_CLR_SEL == `SFIR_CLR_LOW) begin : g_clr_lo
        assign clr_act = ~aclr;
    end else begin : g_clr_none
        assign clr_act = 1'b0;
    end
endgenerate

// mirrored tap i uses unique coefficient min(i, nt-1-i)
function integer uniq_idx;
    input integer i;
    begin
        uniq_idx = (i < NT - 1 - i) ? i : NT - 1 - i;
    end
endfunction

// a product widened to the chain width keeps its sign
function signed [FR-1:0] widen;
    input signed [PW-1:0] p;
    begin
        widen = {{(FR-PW){p[PW-1]}}, p};
    end
endfunction

// =======================================================
// optional input register
// the synchronous reset folds into the next value so that the
// asynchronous branch loads constants only
reg signed [DW-1:0] in_q;
reg signed [DW-1:0] in_d;
wire signed [DW-1:0] x;
always @* begin
    in_d = sample_in;
    if (!rstn) begin
        in_d = `SFIR_ZERO_D;
    end
end
generate
    if (`SFIR_IOREG == 1) begin : g_inreg
        always @(posedge clk or posedge clr_act) begin
            if (clr_act) begin
                in_q <= `SFIR_ZERO_D;
            end else begin
                in_q <= in_d;
            end
        end
        assign x = in_q;
    end else begin : g_inbyp
        always @* begin
            in_q = `SFIR_ZERO_D;
        end
        assign x = sample_in;
    end
endgenerate

// =======================================================
// products: one constant multiplier per distinct coefficient
wire signed [PW-1:0] prod [0:NU-1];
genvar gu;
generate
    for (gu = 0; gu < NU; gu = gu + 1) begin : g_mul
        sfir_cmul #(
            .coef(COEFS[gu*DW +: DW])
        ) u_cmul (
            .data_in(x),
            .prod(prod[gu])
        );
    end
endgenerate

// =======================================================
// transposed chain: psum[i] carries the partial sum toward the output
// every stage is full width so no intermediate bit is lost; each stage
// owns its register so that no array element has two drivers
wire signed [FR-1:0] psum [0:NT-1];
wire signed [FR-1:0] stage_d [0:NT-1];
genvar gt;
generate
    for (gt = 0; gt < NT; gt = gt + 1) begin : g_tap
        reg signed [FR-1:0] acc_q;
        reg signed [FR-1:0] acc_d;
        wire signed [FR-1:0] p_ext = widen(prod[uniq_idx(gt)]);
        if (gt == NT - 1) begin : g_last
            assign stage_d[gt] = p_ext;
        end else begin : g_mid
            assign stage_d[gt] = psum[gt+1] + p_ext;
        end
        always @* begin
            acc_d = stage_d[gt];
            if (!rstn) begin
                acc_d = {FR{1'b0}};
            end
        end
        always @(posedge clk or posedge clr_act) begin
            if (clr_act) begin
                acc_q <= {FR{1'b0}};
            end else begin
                acc_q <= acc_d;
            end
        end
        assign psum[gt] = acc_q;
    end
endgenerate

// =======================================================
// result sizing
// a narrower result keeps the top bits, so it is the full-resolution sum scaled down by 2**(FR-OW)
wire signed [OW-1:0] sized;
generate
    if (OW >= FR) begin : g_ext
        assign sized = {{(OW-FR+1){psum[0][FR-1]}}, psum[0][FR-2:0]};
    end else begin : g_cut
        assign sized = psum[0][FR-1 -: OW];
    end
endgenerate

// =======================================================
// optional output register
// the synchronous reset folds into the next value, as on the input side
reg signed [OW-1:0] out_q;
reg signed [OW-1:0] out_d;
always @* begin
    out_d = sized;
    if (!rstn) begin
        out_d = {OW{1'b0}};
    end
end
generate
    if (`SFIR_IOREG == 1) begin : g_outreg
        always @(posedge clk or posedge clr_act) begin
            if (clr_act) begin
                out_q <= {OW{1'b0}};
            end else begin
                out_q <= out_d;
            end
        end
        assign result_out = out_q;
    end else begin : g_outbyp
        always @* begin
            out_q = {OW{1'b0}};
        end
        assign result_out = sized;
    end
endgenerate

endmodule
`default_nettype wire

// ===== test/sfir_src.sv
/* upstream sample source for sfir_top.
 assumes the bench sets level just after each rising edge. */
`timescale 1ns/1ps
`default_nettype none
module sfir_src (
    input wire logic run,
    input wire logic signed [7:0] level,
    output logic signed [7:0] sample
);
    // a stopped source idles at zero so it adds nothing to the sum
    assign sample = run ? level : 8'h00;
endmodule
`default_nettype wire

// ===== test/sfir_props.sv
/* checker for the ports of sfir_top.
 assumes the io register build and the coefficients of sfir_map.vh. */
`timescale 1ns/1ps
`default_nettype none
`include "sfir_map.vh"
module sfir_props (
    input wire clk,
    input wire rstn,
    input wire aclr,
    input wire signed [`SFIR_D_WIDTH-1:0] sample_in,
    input wire signed [`SFIR_O_EFF-1:0] result_out
);
    // ==========
    // lone sample tracker: age counts zero samples after a clean impulse
    logic [3:0] age_q, zrun_q;
    logic signed [`SFIR_D_WIDTH-1:0] imp_q;
    function automatic logic signed [`SFIR_O_EFF-1:0] tapc(input logic [3:0] a);
        case (a > 4'h5 ? 4'hb - a : a)
            4'h0: return 20'sh40;
            4'h1: return 20'sh27;
            4'h3: return -20'sh0a;
            4'h5: return 20'sh3;
            default: return 20'sh0;
        endcase
    endfunction
    always @(posedge clk) begin
        if (!rstn || aclr) begin
            age_q <= 4'hf;
            zrun_q <= 4'hf;
        end else if (sample_in != 0) begin
            age_q <= (zrun_q >= 4'hc) ? 4'h0 : 4'hf;
            imp_q <= sample_in;
            zrun_q <= 4'h0;
        end else begin
            age_q <= (age_q == 4'hf) ? age_q : age_q + 4'h1;
            zrun_q <= (zrun_q == 4'hf) ? zrun_q : zrun_q + 4'h1;
        end
    end
    // ==========
    // assertions
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn || aclr);
    chk_clear_zero: assert property (disable iff (!rstn) aclr |-> result_out == 0)
        else $error("result not zero under clear");
    chk_reset_clears: assert property (disable iff (aclr) !rstn |=> result_out == 0)
        else $error("result not zero after reset");
    chk_release_flush: assert property ($fell(aclr) |-> (result_out == 0)[*3])
        else $error("stale value after clear release");
    chk_tap_profile: assert property (age_q < 4'hc |->
        ##2 result_out == tapc($past(age_q, 2)) * $past(imp_q, 2))
        else $error("impulse response wrong");
    chk_first_tap: assert property (age_q == 4'h0 |-> ##2 result_out == 20'sh40 * $past(imp_q, 2))
        else $error("first tap late or wrong");
    chk_zero_tap: assert property (age_q == 4'h2 || age_q == 4'h4 |-> ##2 result_out == 0)
        else $error("zero tap contributes");
    chk_neg_coef: assert property (age_q == 4'h3 |-> ##2 result_out == -20'sh0a * $past(imp_q, 2))
        else $error("negative tap wrong");
    chk_quiet_zero: assert property (zrun_q >= 4'he |-> result_out == 0)
        else $error("result not zero on silent input");
    cover property (age_q == 4'hb);
    cover property (age_q == 4'h3);
    cover property ($fell(aclr));
endmodule
bind sfir_top sfir_props chk (.clk(clk), .rstn(rstn), .aclr(aclr), .sample_in(sample_in),
    .result_out(result_out));
`default_nettype wire

// ===== test/tb.sv
/* self-checking bench for sfir_top fed by sfir_src.
 assumes io registers, full resolution and an active high clear. */
`timescale 1ns/1ps
`default_nettype none
`include "sfir_map.vh"
module tb;
    logic clk = 1'b0, rstn = 1'b0, aclr = 1'b0, run = 1'b0;
    logic signed [7:0] level = 8'h00;
    wire signed [7:0] sample;
    wire signed [`SFIR_O_EFF-1:0] result;
    int mismatches = 0, n_compared = 0, cyc = 0, hist[12];
    int cf[12] = '{64, 39, 0, -10, 0, 3, 3, 0, -10, 0, 39, 64};
    logic signed [`SFIR_O_EFF-1:0] q[$];
    sfir_src src (.run(run), .level(level), .sample(sample));
    sfir_top uut (.clk(clk), .rstn(rstn), .aclr(aclr), .sample_in(sample), .result_out(result));
    initial begin
        forever #4 clk = ~clk;
    end
    // ==========
    // expectation model and output watcher
    always @(posedge clk) begin
        int s;
        if (!rstn || aclr) begin
            hist = '{default: 0};
            q.delete();
        end else begin
            s = 0;
            for (int k = 11; k > 0; k--) hist[k] = hist[k-1];
            hist[0] = sample;
            for (int k = 0; k < 12; k++) s += cf[k] * hist[k];
            q.push_back(s[`SFIR_O_EFF-1:0]);
        end
    end
    // a note waits two edges behind the one that took its sample
    always @(posedge clk) begin
        #2;
        // a clear raised just after this edge voids the note; it is checked below
        if (q.size() > 2 && !aclr) check(q.pop_front(), result);
    end
    // ceiling well above the few hundred cycles the tests need
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            mismatches++;
            summarize();
        end
    end
    task automatic check(input logic signed [`SFIR_O_EFF-1:0] exp, got);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected at %0t: result %0d, expected %0d", $time, got, exp);
        end
    endtask
    task automatic drive(input logic signed [7:0] v, input int n);
        repeat (n) begin
            @(posedge clk);
            #1 level = v;
        end
    endtask
    task automatic summarize;
        $display("compared %0d, mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // ==========
    // tests
    initial begin
        void'($urandom(56));
        drive(8'h00, 3);
        rstn = 1'b1;
        run = 1'b1;
        drive(8'h64, 1);
        drive(8'h00, 14);
        drive(8'h80, 1);
        drive(8'h00, 14);
        $display("test impulse done");
        drive(8'h7f, 14);
        drive(8'h80, 14);
        $display("test extremes done");
        repeat (300) drive(8'($urandom()), 1);
        $display("test random done");
        aclr = 1'b1;
        #1 check('0, result);
        drive(8'h55, 2);
        aclr = 1'b0;
        repeat (20) drive(8'($urandom()), 1);
        $display("test clear done");
        rstn = 1'b0;
        drive(8'h33, 2);
        check('0, result);
        rstn = 1'b1;
        repeat (20) drive(8'($urandom()), 1);
        run = 1'b0;
        drive(8'h00, 16);
        $display("test reset done");
        summarize();
    end
endmodule
`default_nettype wire
